// [src/pdsm_mgmt.sv]
// serial management port frame engine and basic management register set
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - registers 0..6 implemented, readable and writable as standard defines
// - vendor registers 16..18 decoded on the port; 19..31 read zero
// - reads of registers 7..15 return all ones
// - address-ignore bit 3 of register 17 accepts any device address
// - data line open-drain two-way, pulled low or released only
// - receiver samples the data line on each rising clock edge
// - commands flow in serially, register data flows back on same line
// - register 0: reset 15, loopback 14, speed 13, negotiate 12, power down 11
// - register 0: isolate 10, restart 9, duplex 8, collision test 7, 6..0 reserved
// - register 1 reports ability bits 15..11 and status bits 5..0
// - registers 2,3 hold identifier; register 3 has model and revision low
// - register 4 advertisement layout with pause, abilities and selector
// - register 5 reports partner base page fields
// - register 6 reports detect fault, partner next-page ability, page received, partner able
// - no next-page exchange; register 7 wholly reserved
// - register 8 reserved in all bits
// - negotiation off forces speed from bit 13 and duplex from bit 8
// - advertisement write takes effect only after a restart
// - link by parallel detection clears register 6 bit 0
module pdsm_mgmt #(
  parameter logic [15:0] ID_HIGH_VAL = 16'h1234, // arbitrary identifier value
  parameter logic [15:0] ID_LOW_VAL  = 16'h5671, // arbitrary identifier value
  parameter logic [15:0] VREV_VAL    = 16'h0040  // arbitrary revision value
) (
  // core clock domain
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // management link
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  // strap and line status from the transceiver
  input  wire logic [4:0]  phyad_strap,
  input  wire logic        link_up,
  input  wire logic        an_done,
  input  wire logic        an_res_100,
  input  wire logic        an_res_full,
  input  wire logic        rfault_ev,
  input  wire logic        jabber_ev,
  input  wire logic [15:0] partner_ability,
  input  wire logic        partner_np_able,
  input  wire logic        page_rx_ev,
  input  wire logic        flp_seen_ev,
  input  wire logic        pd_link_ev,
  input  wire logic        pd_fault_ev,
  // control to the transceiver
  output logic             soft_reset,
  output logic             an_restart,
  output logic             an_enable,
  output logic             loopback,
  output logic             power_down,
  output logic             isolate,
  output logic             coll_test,
  output logic             speed_100,
  output logic             full_duplex,
  output logic [15:0]      adv_active,
  output logic [15:0]      mode_ctrl
);
  import pdsm_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // sticky flag: a set in the clearing cycle wins
  function automatic logic sticky(input logic set, input logic clr, input logic cur);
    sticky = set | (cur & ~clr);
  endfunction : sticky

  // one bit placed in an otherwise zero word
  function automatic logic [15:0] put_bit(input logic b, input int pos);
    put_bit      = WORD_ZERO;
    put_bit[pos] = b;
  endfunction : put_bit

  // ****************************************************************
  // link domain: frame engine on the management clock
  // ****************************************************************
  pdsm_frm_t   st_reg;
  pdsm_frm_t   st_next;
  logic [3:0]  cnt_reg;
  logic [3:0]  cnt_next;
  logic [5:0]  ones_reg;
  logic [5:0]  ones_next;
  logic [1:0]  op_reg;
  logic [1:0]  op_next;
  logic [4:0]  raddr_reg;
  logic [4:0]  raddr_next;
  logic [4:0]  waddr_reg;
  logic [4:0]  waddr_next;
  logic [15:0] wdata_reg;
  logic [15:0] wdata_next;
  logic [15:0] sh_reg;
  logic        drv_reg;
  logic        drv_next;
  logic        rd_tgl_reg;
  logic        rd_tgl_next;
  logic        wr_tgl_reg;
  logic        wr_tgl_next;
  logic [5:0]  cfg_link;
  logic [15:0] rdata_reg;
  logic [15:0] vmode_reg;
  logic [15:0] vspec_reg;

  // address config crosses as a quasi-static level, settled during preamble
  pdsm_sync #(.W(6)) u_cfg_sync (
    .clk (mdc),
    .rst (sys_rst),
    .ce  (1'b1),
    .d   ({vmode_reg[VMODE_ADDR_IGN], vspec_reg[4:0]}),
    .q   (cfg_link)
  );

  // decoded fields of the incoming bit stream
  wire [15:0] sh_nx    = {sh_reg[14:0], mdio_in};
  wire        addr_ok  = cfg_link[5] || (sh_nx[9:5] == cfg_link[4:0]);
  wire        op_ok    = (sh_nx[1:0] == OP_READ) || (sh_nx[1:0] == OP_WRITE);
  wire [3:0]  cnt_inc  = cnt_reg + 4'h1;
  wire [3:0]  bit_idx  = DATA_LAST - cnt_reg;
  wire        ones_sat = (ones_reg == PRE_MIN);

  // frame sequencing, one step per rising edge of the management clock
  always_comb begin
    st_next     = st_reg;
    cnt_next    = cnt_inc;
    ones_next   = ones_reg;
    op_next     = op_reg;
    raddr_next  = raddr_reg;
    waddr_next  = waddr_reg;
    wdata_next  = wdata_reg;
    drv_next    = 1'b0;
    rd_tgl_next = rd_tgl_reg;
    wr_tgl_next = wr_tgl_reg;
    case (st_reg)
      PDSM_PRE: begin
        cnt_next = 4'h0;
        if (mdio_in) begin
          ones_next = ones_sat ? ones_reg : ones_reg + 6'h01;
        end else begin
          ones_next = 6'h00;
          if (ones_sat) st_next = PDSM_START;
        end
      end
      PDSM_START: begin
        cnt_next = 4'h0;
        st_next  = mdio_in ? PDSM_OP : PDSM_PRE;
      end
      PDSM_OP: begin
        if (cnt_reg == OP_LAST) begin
          op_next  = sh_nx[1:0];
          cnt_next = 4'h0;
          st_next  = op_ok ? PDSM_ADDR : PDSM_PRE;
        end
      end
      PDSM_ADDR: begin
        if (cnt_reg == ADDR_LAST) begin
          cnt_next = 4'h0;
          if (!addr_ok) begin
            st_next = PDSM_PRE;
          end else if (op_reg == OP_READ) begin
            raddr_next  = sh_nx[4:0];
            rd_tgl_next = ~rd_tgl_reg;
            st_next     = PDSM_RTA;                              // released for first bit
          end else begin
            waddr_next = sh_nx[4:0];
            st_next    = PDSM_WTA;
          end
        end
      end
      PDSM_WTA: begin
        if (cnt_reg == TA_LAST) begin
          cnt_next = 4'h0;
          st_next  = PDSM_WDATA;
        end
      end
      PDSM_WDATA: begin
        if (cnt_reg == DATA_LAST) begin
          wdata_next  = sh_nx;
          wr_tgl_next = ~wr_tgl_reg;
          st_next     = PDSM_PRE;
        end
      end
      PDSM_RTA: begin
        cnt_next = 4'h0;
        drv_next = 1'b1;
        st_next  = PDSM_RDATA;
      end
      PDSM_RDATA: begin
        drv_next = ~rdata_reg[bit_idx];
        if (cnt_reg == DATA_LAST) st_next = PDSM_PRE;
      end
      default: st_next = PDSM_PRE;
    endcase
  end

  // link-side state, clocked only by the manager's edges
  always_ff @(posedge mdc or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg   <= PDSM_PRE;
      cnt_reg  <= 4'h0;
      ones_reg <= 6'h00;
      op_reg   <= 2'b00;
      sh_reg   <= 16'h0000;
      drv_reg  <= 1'b0;
    end else begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      ones_reg <= ones_next;
      op_reg   <= op_next;
      sh_reg   <= sh_nx;
      drv_reg  <= drv_next;
    end
  end

  // request words held stable until the next frame of the same kind
  always_ff @(posedge mdc or posedge sys_rst) begin
    if (sys_rst) begin
      raddr_reg  <= 5'h00;
      waddr_reg  <= 5'h00;
      wdata_reg  <= 16'h0000;
      rd_tgl_reg <= 1'b0;
      wr_tgl_reg <= 1'b0;
    end else begin
      raddr_reg  <= raddr_next;
      waddr_reg  <= waddr_next;
      wdata_reg  <= wdata_next;
      rd_tgl_reg <= rd_tgl_next;
      wr_tgl_reg <= wr_tgl_next;
    end
  end

  // open drain: only ever pull low
  assign mdio_out = 1'b0;
  assign mdio_oe  = drv_reg;

  // ****************************************************************
  // core domain: request crossing
  // ****************************************************************
  logic [1:0] tgl_core;
  logic       rd_seen_reg;
  logic       wr_seen_reg;

  pdsm_sync #(.W(2)) u_tgl_sync (
    .clk (core_clk),
    .rst (sys_rst),
    .ce  (clk_en),
    .d   ({rd_tgl_reg, wr_tgl_reg}),
    .q   (tgl_core)
  );

  // address and data words are stable by the time a toggle arrives;
  // read data is ready long before the second turnaround edge
  wire rd_ev = tgl_core[1] ^ rd_seen_reg;
  wire wr_ev = tgl_core[0] ^ wr_seen_reg;

  // write and read strobes per register
  wire wr_ctrl  = wr_ev && (waddr_reg == REG_CTRL);
  wire wr_adv   = wr_ev && (waddr_reg == REG_ADV);
  wire wr_vmode = wr_ev && (waddr_reg == REG_VMODE);
  wire wr_vspec = wr_ev && (waddr_reg == REG_VSPEC);
  wire rd_stat  = rd_ev && (raddr_reg == REG_STATUS);
  wire rd_exp   = rd_ev && (raddr_reg == REG_EXPAND);

  // ****************************************************************
  // core domain: register set
  // ****************************************************************
  logic [15:0] ctrl_reg;
  logic [15:0] adv_reg;
  logic [15:0] adv_act_reg;
  logic        strap_done_reg;
  logic        link_lat_reg;
  logic        rfault_reg;
  logic        jabber_reg;
  logic        pd_fault_reg;
  logic        page_rx_reg;
  logic        lp_an_reg;
  logic        speed_reg;
  logic        duplex_reg;

  // reset and restart self-clear one cycle after being written
  wire        sw_rst    = ctrl_reg[CTL_RESET];
  wire        restart   = ctrl_reg[CTL_RESTART];
  wire [15:0] ctrl_next = sw_rst  ? CTRL_RST_VAL :
                          wr_ctrl ? (wdata_reg & CTRL_WR_MASK) :
                          (ctrl_reg & ~CTRL_SELF_CLR);
  // next-page bit stays zero; selector is fixed
  wire [15:0] adv_next  = sw_rst ? ADV_RST_VAL :
                          wr_adv ? ((wdata_reg & ADV_WR_MASK) | ADV_SELECTOR) :
                          adv_reg;
  wire [15:0] vmode_next = sw_rst   ? VMODE_RST_VAL :
                           wr_vmode ? (wdata_reg & VMODE_WR_MASK) : vmode_reg;
  wire [15:0] vspec_next = !strap_done_reg ? {vspec_reg[15:5], phyad_strap} :
                           wr_vspec ? (wdata_reg & VSPEC_WR_MASK) : vspec_reg;

  // writable registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg       <= CTRL_RST_VAL;
      adv_reg        <= ADV_RST_VAL;
      vmode_reg      <= VMODE_RST_VAL;
      vspec_reg      <= WORD_ZERO;
      strap_done_reg <= 1'b0;
    end else if (clk_en) begin
      ctrl_reg       <= ctrl_next;
      adv_reg        <= adv_next;
      vmode_reg      <= vmode_next;
      vspec_reg      <= vspec_next;
      strap_done_reg <= 1'b1;
    end
  end

  // abilities in use change only on restart or reset, not on a write
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      adv_act_reg <= ADV_RST_VAL;
    end else if (clk_en && (restart || sw_rst)) begin
      adv_act_reg <= sw_rst ? ADV_RST_VAL : adv_reg;
    end
  end

  // latched status: link latches low, faults latch high, reads clear all but partner-able, which parallel detection clears
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_lat_reg <= 1'b0;
      rfault_reg   <= 1'b0;
      jabber_reg   <= 1'b0;
      pd_fault_reg <= 1'b0;
      page_rx_reg  <= 1'b0;
      lp_an_reg    <= 1'b0;
    end else if (clk_en) begin
      link_lat_reg <= rd_stat ? link_up : (link_lat_reg & link_up);
      rfault_reg   <= sticky(rfault_ev, rd_stat, rfault_reg);
      jabber_reg   <= sticky(jabber_ev, rd_stat, jabber_reg);
      pd_fault_reg <= sticky(pd_fault_ev, rd_exp, pd_fault_reg);
      page_rx_reg  <= sticky(page_rx_ev, rd_exp, page_rx_reg);
      lp_an_reg    <= sticky(flp_seen_ev, pd_link_ev, lp_an_reg);
    end
  end

  // status words seen by the read-back
  wire [15:0] stat_word = STAT_FIXED
                        | put_bit(an_done, ST_AN_DONE)
                        | put_bit(rfault_reg, ST_RFAULT)
                        | put_bit(link_lat_reg, ST_LINK)
                        | put_bit(jabber_reg, ST_JABBER);
  wire [15:0] exp_word  = put_bit(pd_fault_reg, EXP_PD_FAULT)
                        | put_bit(partner_np_able, EXP_LP_NP)
                        | put_bit(page_rx_reg, EXP_PAGE_RX)
                        | put_bit(lp_an_reg, EXP_LP_AN);
  wire [15:0] rd_word;

  pdsm_read_mux u_read_mux (
    .reg_addr     (raddr_reg),
    .ctrl_word    (ctrl_reg),
    .stat_word    (stat_word),
    .id_high_word (ID_HIGH_VAL),
    .id_low_word  (ID_LOW_VAL),
    .adv_word     (adv_reg),
    .partner_word (partner_ability),
    .expand_word  (exp_word),
    .vrev_word    (VREV_VAL),
    .vmode_word   (vmode_reg),
    .vspec_word   (vspec_reg),
    .rd_word      (rd_word)
  );

  // capture read data and retire the request toggles
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg   <= 16'h0000;
      rd_seen_reg <= 1'b0;
      wr_seen_reg <= 1'b0;
    end else if (clk_en) begin
      if (rd_ev) rdata_reg <= rd_word;
      rd_seen_reg <= tgl_core[1];
      wr_seen_reg <= tgl_core[0];
    end
  end

  // forced mode applies only with negotiation off
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      speed_reg  <= 1'b0;
      duplex_reg <= 1'b0;
    end else if (clk_en) begin
      speed_reg  <= ctrl_reg[CTL_AN_EN] ? an_res_100  : ctrl_reg[CTL_SPEED];
      duplex_reg <= ctrl_reg[CTL_AN_EN] ? an_res_full : ctrl_reg[CTL_DUPLEX];
    end
  end

  // ****************************************************************
  // control outputs
  // ****************************************************************
  assign soft_reset  = sw_rst;
  assign an_restart  = restart;
  assign an_enable   = ctrl_reg[CTL_AN_EN];
  assign loopback    = ctrl_reg[CTL_LOOP];
  assign power_down  = ctrl_reg[CTL_PWR_DOWN];
  assign isolate     = ctrl_reg[CTL_ISOLATE];
  assign coll_test   = ctrl_reg[CTL_COLTEST];
  assign speed_100   = speed_reg;
  assign full_duplex = duplex_reg;
  assign adv_active  = adv_act_reg;
  assign mode_ctrl   = vmode_reg;

endmodule : pdsm_mgmt
`default_nettype wire

// [src/pdsm_pkg.sv]
// package: register map, field layout and frame constants of the management port
package pdsm_pkg;

  // ****************************************************************
  // register numbers
  // ****************************************************************
  localparam logic [4:0]  REG_CTRL     = 5'h00;
  localparam logic [4:0]  REG_STATUS   = 5'h01;
  localparam logic [4:0]  REG_ID_HIGH  = 5'h02;
  localparam logic [4:0]  REG_ID_LOW   = 5'h03;
  localparam logic [4:0]  REG_ADV      = 5'h04;
  localparam logic [4:0]  REG_PARTNER  = 5'h05;
  localparam logic [4:0]  REG_EXPAND   = 5'h06;
  localparam logic [4:0]  REG_NP_TX    = 5'h07;
  localparam logic [4:0]  REG_RSV_LAST = 5'h0F;
  localparam logic [4:0]  REG_VREV     = 5'h10;
  localparam logic [4:0]  REG_VMODE    = 5'h11;
  localparam logic [4:0]  REG_VSPEC    = 5'h12;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTL_RESET    = 15;
  localparam int CTL_LOOP     = 14;
  localparam int CTL_SPEED    = 13;
  localparam int CTL_AN_EN    = 12;
  localparam int CTL_PWR_DOWN = 11;
  localparam int CTL_ISOLATE  = 10;
  localparam int CTL_RESTART  = 9;
  localparam int CTL_DUPLEX   = 8;
  localparam int CTL_COLTEST  = 7;
  localparam int ST_AN_DONE   = 5;
  localparam int ST_RFAULT    = 4;
  localparam int ST_LINK      = 2;
  localparam int ST_JABBER    = 1;
  localparam int EXP_PD_FAULT = 4;
  localparam int EXP_LP_NP    = 3;
  localparam int EXP_PAGE_RX  = 1;
  localparam int EXP_LP_AN    = 0;
  localparam int VMODE_ADDR_IGN = 3;

  // ****************************************************************
  // reset values and masks
  // ****************************************************************
  localparam logic [15:0] ALL_ONES       = 16'hFFFF;
  localparam logic [15:0] WORD_ZERO      = 16'h0000;
  localparam logic [15:0] CTRL_RST_VAL   = 16'h3000;
  localparam logic [15:0] CTRL_WR_MASK   = 16'hFF80;
  localparam logic [15:0] CTRL_SELF_CLR  = 16'h8200;
  localparam logic [15:0] STAT_FIXED     = 16'h7809;
  localparam logic [15:0] ADV_RST_VAL    = 16'h01E1;
  localparam logic [15:0] ADV_WR_MASK    = 16'h2FE0;
  localparam logic [15:0] ADV_SELECTOR   = 16'h0001;
  localparam logic [15:0] VMODE_RST_VAL  = 16'h0000;
  localparam logic [15:0] VMODE_WR_MASK  = 16'h6F1C;
  localparam logic [15:0] VSPEC_WR_MASK  = 16'h00FF;

  // ****************************************************************
  // frame layout
  // ****************************************************************
  localparam logic [1:0] OP_READ    = 2'b10;
  localparam logic [1:0] OP_WRITE   = 2'b01;
  localparam logic [5:0] PRE_MIN    = 6'h20;
  localparam logic [3:0] OP_LAST    = 4'h1;
  localparam logic [3:0] ADDR_LAST  = 4'h9;
  localparam logic [3:0] TA_LAST    = 4'h1;
  localparam logic [3:0] DATA_LAST  = 4'hF;

  typedef enum logic [2:0] {
    PDSM_PRE   = 3'b000,
    PDSM_START = 3'b001,
    PDSM_OP    = 3'b010,
    PDSM_ADDR  = 3'b011,
    PDSM_WTA   = 3'b100,
    PDSM_WDATA = 3'b101,
    PDSM_RTA   = 3'b110,
    PDSM_RDATA = 3'b111
  } pdsm_frm_t;

endpackage : pdsm_pkg

// [src/pdsm_read_mux.sv]
// read-back selection of the management register words
`timescale 1ns/100ps
`default_nettype none
module pdsm_read_mux (
  // register number
  input  wire logic [4:0]  reg_addr,
  // register words
  input  wire logic [15:0] ctrl_word,
  input  wire logic [15:0] stat_word,
  input  wire logic [15:0] id_high_word,
  input  wire logic [15:0] id_low_word,
  input  wire logic [15:0] adv_word,
  input  wire logic [15:0] partner_word,
  input  wire logic [15:0] expand_word,
  input  wire logic [15:0] vrev_word,
  input  wire logic [15:0] vmode_word,
  input  wire logic [15:0] vspec_word,
  // selected word
  output logic      [15:0] rd_word
);
  import pdsm_pkg::*;

  // 7..15 includes the next-page and 8 slots: all read back as ones
  wire in_rsvd = (reg_addr >= REG_NP_TX) && (reg_addr <= REG_RSV_LAST);

  // basic/extended words, then vendor words; other vendor slots read zero
  assign rd_word = in_rsvd                    ? ALL_ONES     :
                   (reg_addr == REG_CTRL)     ? ctrl_word    :
                   (reg_addr == REG_STATUS)   ? stat_word    :
                   (reg_addr == REG_ID_HIGH)  ? id_high_word :
                   (reg_addr == REG_ID_LOW)   ? id_low_word  :
                   (reg_addr == REG_ADV)      ? adv_word     :
                   (reg_addr == REG_PARTNER)  ? partner_word :
                   (reg_addr == REG_EXPAND)   ? expand_word  :
                   (reg_addr == REG_VREV)     ? vrev_word    :
                   (reg_addr == REG_VMODE)    ? vmode_word   :
                   (reg_addr == REG_VSPEC)    ? vspec_word   :
                   WORD_ZERO;

endmodule : pdsm_read_mux
`default_nettype wire

// [src/pdsm_sync.sv]
// two-stage level synchroniser with clock enable
`timescale 1ns/100ps
`default_nettype none
module pdsm_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // level in, synchronised level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q        <= '0;
    end else if (ce) begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : pdsm_sync
`default_nettype wire

// [test/pdsm_mgmt_monitor.sv]
// checker: port-level assertions of the management block
`timescale 1ns/100ps
`default_nettype none
module pdsm_mgmt_monitor (
  // clocks and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic mdc,
  // link
  input wire logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  // results and controls
  input wire logic an_res_100,
  input wire logic an_res_full,
  input wire logic soft_reset,
  input wire logic an_restart,
  input wire logic an_enable,
  input wire logic loopback,
  input wire logic power_down,
  input wire logic isolate,
  input wire logic speed_100,
  input wire logic full_duplex
);
  logic [4:0] oe_run_reg;
  // length of a drive run; a driver that never lets go overruns 17
  always_ff @(posedge mdc or posedge sys_rst)
    if (sys_rst) oe_run_reg <= 5'h00;
    else oe_run_reg <= mdio_oe ? oe_run_reg + 5'h01 : 5'h00;
  // control levels after a software reset
  sequence s_ctl_defaults;
    an_enable && !loopback && !power_down && !isolate;
  endsequence
  chk_out_low: assert property (
    @(posedge core_clk) disable iff (sys_rst) mdio_out == 1'b0) else $error("output high");
  chk_drive_low: assert property (
    @(posedge mdc) disable iff (sys_rst) mdio_oe |-> !mdio_in) else $error("line not low");
  chk_drive_span: assert property (
    @(posedge mdc) disable iff (sys_rst) oe_run_reg <= 5'h11) else $error("drive too long");
  chk_speed_follow: assert property (
    @(posedge core_clk) disable iff (sys_rst) $past(an_enable & ~sys_rst)
    |-> speed_100 == $past(an_res_100)) else $error("speed not negotiated");
  chk_duplex_follow: assert property (
    @(posedge core_clk) disable iff (sys_rst) $past(an_enable & ~sys_rst)
    |-> full_duplex == $past(an_res_full)) else $error("duplex not negotiated");
  chk_restart_pulse: assert property (
    @(posedge core_clk) disable iff (sys_rst) an_restart |=> !an_restart) else $error("restart");
  chk_reset_pulse: assert property (
    @(posedge core_clk) disable iff (sys_rst) soft_reset |=> !soft_reset) else $error("reset");
  chk_reset_restore: assert property (
    @(posedge core_clk) disable iff (sys_rst) soft_reset |=> ##[0:1] s_ctl_defaults)
    else $error("defaults lost");
endmodule : pdsm_mgmt_monitor
bind pdsm_mgmt pdsm_mgmt_monitor u_mon (.*);
`default_nettype wire

// [test/pdsm_station_mgr.sv]
// station manager model: makes the clock and drives frames
`timescale 1ns/100ps
`default_nettype none
module pdsm_station_mgr (
  // link
  output logic      mdc,
  output logic      mdio_pull,
  input  wire logic mdio_line
);
  import pdsm_pkg::*;
  // clock stands low between frames; 400 ns bit time keeps edge spacing
  initial begin
    mdc = 1'b0;
    mdio_pull = 1'b0;
  end
  // one frame; rx keeps turnaround and data as seen on the line
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, ra,
                       input logic [15:0] wd, output logic [17:0] rx);
    logic [63:0] bits;
    bits = {32'hFFFF_FFFF, 2'b01, op, pa, ra, 2'b10, wd};
    for (int i = 63; i >= 0; i--) begin
      #20 mdio_pull = (op == OP_READ && i < 18) ? 1'b0 : ~bits[i];
      #180 mdc = 1'b1;
      rx = {rx[16:0], mdio_line};
      #200 mdc = 1'b0;
    end
    #20 mdio_pull = 1'b0;
  endtask : frame
endmodule : pdsm_station_mgr
`default_nettype wire

// [test/phy_serial_management_regs_test.sv]
// testbench: register reads and writes over the management link
`timescale 1ns/100ps
`default_nettype none
module phy_serial_management_regs_test;
  import pdsm_pkg::*;
  localparam logic [15:0] ID_HI = 16'h0A0B; // arbitrary value
  localparam logic [15:0] ID_LO = 16'h0C0D; // arbitrary value
  localparam logic [15:0] REV   = 16'h0050; // arbitrary value
  logic core_clk, sys_rst, clk_en, mdc, mdio_in, mdio_out, mdio_oe, mgr_pull, link_up;
  logic an_done, an_res_100, an_res_full, rfault_ev, jabber_ev, partner_np_able, page_rx_ev;
  logic flp_seen_ev, pd_link_ev, pd_fault_ev, soft_reset, an_restart, an_enable, loopback;
  logic power_down, isolate, coll_test, speed_100, full_duplex;
  logic [4:0]  phyad_strap;
  logic [15:0] partner_ability, adv_active, mode_ctrl, v;
  logic [31:0] e;
  logic [6:0]  s;
  logic [17:0] rx;
  int          err_count, compares;
  // pull-up on the shared line; either side may pull it low
  assign mdio_in = ~(mgr_pull | (mdio_oe & ~mdio_out));
  pdsm_mgmt #(.ID_HIGH_VAL(ID_HI), .ID_LOW_VAL(ID_LO), .VREV_VAL(REV)) dut (.*);
  pdsm_station_mgr u_mgr (.mdc(mdc), .mdio_pull(mgr_pull), .mdio_line(mdio_in));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // line status wanders every cycle; events are rare pulses
  always @(posedge core_clk) begin
    #1 {an_res_100, an_res_full, link_up, an_done} = 4'($urandom);
    {rfault_ev, jabber_ev, page_rx_ev, flp_seen_ev, pd_link_ev, pd_fault_ev} =
      ($urandom % 16 == 0) ? 6'($urandom) : 6'h00;
  end
  task automatic check(input string name, input logic [17:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    u_mgr.frame(OP_WRITE, 5'h05, ra, d, rx);
    repeat (10) @(posedge core_clk);
  endtask : wr
  // expected word and compared bits; live status bits are masked out
  function automatic logic [31:0] exp_reg(input int r);
    case (r)
      0: return {16'hFFFF, 16'h3000};
      1: return {16'hFFC9, 16'h7809};
      2: return {16'hFFFF, ID_HI};
      3: return {16'hFFFF, ID_LO};
      4: return {16'hFFFF, 16'h01E1};
      5: return {16'hFFFF, partner_ability};
      6: return {16'hFFEC, 12'h000, partner_np_able, 3'h0};
      16: return {16'hFFFF, REV};
      17, 19: return {16'hFFFF, 16'h0000};
      18: return {16'hFFFF, 16'h0005};
      default: return {16'hFFFF, 16'hFFFF};
    endcase
  endfunction : exp_reg
  // hang guard
  initial begin
    #1_000_000 err_count++;
    end_of_test;
  end
  initial begin
    void'($urandom(21880));
    {sys_rst, clk_en, phyad_strap} = 7'h65;
    {partner_ability, partner_np_able} = 17'($urandom);
    repeat (8) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge core_clk);
    for (int r = 0; r <= 19; r++) begin
      u_mgr.frame(OP_READ, 5'h05, 5'(r), 16'h0000, rx);
      e = exp_reg(r);
      check("word", rx & {2'h3, e[31:16]}, {2'h2, e[15:0]});
    end
    $display("default words done");
    v = 16'($urandom);
    wr(REG_ADV, v);
    check("adv held", {2'h0, adv_active}, 18'h0_01E1);
    u_mgr.frame(OP_READ, 5'h05, REG_ADV, 16'h0000, rx);
    check("adv", rx, {2'h2, (v & 16'h2FE0) | 16'h0001});
    wr(REG_CTRL, 16'h1200);
    check("adv used", {2'h0, adv_active}, {2'h0, (v & 16'h2FE0) | 16'h0001});
    $display("advertisement done");
    v = 16'($urandom) & 16'h6D80;
    wr(REG_CTRL, v);
    s = {an_enable, loopback, speed_100, power_down, isolate, full_duplex, coll_test};
    check("forced", 18'(s), 18'({1'b0, v[14:13], v[11:10], v[8:7]}));
    $display("forced mode done");
    u_mgr.frame(OP_READ, 5'h06, REG_ID_HIGH, 16'h0000, rx);
    check("foreign", rx, 18'h3_FFFF);
    wr(REG_VMODE, 16'h0008);
    u_mgr.frame(OP_READ, 5'h06, REG_ID_HIGH, 16'h0000, rx);
    check("any addr", rx, {2'h2, ID_HI});
    wr(REG_CTRL, 16'h8000);
    check("mode", {2'h0, mode_ctrl}, 18'h0_0000);
    check("adv rst", {2'h0, adv_active}, 18'h0_01E1);
    u_mgr.frame(OP_READ, 5'h05, REG_CTRL, 16'h0000, rx);
    check("ctrl", rx, 18'h2_3000);
    $display("address and reset done");
    end_of_test;
  end
endmodule : phy_serial_management_regs_test
`default_nettype wire
